/* File: hdl/fcs_regs.vh */
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// --------------------------------------------------------------------
// register indices and byte addresses
// --------------------------------------------------------------------
`define FCS_IDX_CTRL_FIRST 6'h00
`define FCS_IDX_CTRL_SECOND 6'h01
`define FCS_IDX_STATUS 6'h02
`define FCS_ADDR_CTRL_FIRST {`FCS_IDX_CTRL_FIRST, 2'h0}
`define FCS_ADDR_CTRL_SECOND {`FCS_IDX_CTRL_SECOND, 2'h0}
`define FCS_ADDR_STATUS {`FCS_IDX_STATUS, 2'h0}
// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define FCS_BIT_ENABLE 0
`define FCS_BIT_FAULT_NMI_ENABLE 1
`define FCS_BIT_RESET 7
`define FCS_BIT_BUSY 0
`define FCS_BIT_OK 1
// --------------------------------------------------------------------
// section select codes and start-up fuse code
// --------------------------------------------------------------------
`define FCS_SEC_FLASH 2'h0
`define FCS_SEC_BOOT_APP 2'h1
`define FCS_SEC_BOOT 2'h2
`define FCS_FUSE_NO_SCAN 2'h3
// --------------------------------------------------------------------
// checksum constants and timing
// --------------------------------------------------------------------
`define FCS_POLY16 32'h00001021
`define FCS_POLY32 32'h04C11DB7
`define FCS_CRC_INIT16 32'h0000FFFF
`define FCS_CRC_INIT32 32'hFFFFFFFF
`define FCS_START_DELAY 2'h3
`define FCS_REF_LEN16 2'h2
`define FCS_REF_LEN32 3'h4
`endif

/* File: hdl/fcs_scanner.v */
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "fcs_regs.vh"
// Notes on behaviour
// - section select written first; scan starts three cycles after enable, CPU keeps running.
// - 16 or 32 bit checksum chosen by fuse input, not by a register.
// - fuse-configured start-up scan runs before CPU start; failure keeps CPU held.
// - after pass CPU runs, enable reads 1, section shows scanned area, pass 1.
// - after start-up failure CPU held, enable 1, section shown, pass 0.
// - during a scan the scanner owns flash and stalls the CPU.
// - each 16-bit flash fetch of the scanner takes three cycles.
// - 16-bit mode polynomial x16+x12+x5+1.
// - 32-bit mode uses the Ethernet polynomial.
// - bytes processed one at a time from address 0, one update per byte.
// - each byte enters the shift register most significant bit first.
// - running checksum preset to all ones at every scan start.
// - coverage is whole flash, boot only, or boot plus application.
// - busy set while scanning; pass flag shows checksum match.
// - mismatch raises non-maskable interrupt request when enabled.
// - section codes 0 whole flash, 1 boot plus app, 2 boot, 3 reserved.
// - interrupt enable stays set until system reset; the reset strobe leaves it set.
// - in CPU sleep the scanner pauses and resumes on wake.
// - enable stays 1 after scan; writing 1 restarts unless an nmi request is pending, writing 0 ignored.
module fcs_scanner #(
  parameter AW = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // fuses
  input wire fuse_crc32,
  input wire [1:0] fuse_scan_source,
  input wire [AW-1:0] boot_section_last_byte,
  input wire [AW-1:0] app_section_last_byte,
  input wire [AW-1:0] flash_last_byte,
  // flash read port
  output reg flash_rd,
  output reg [AW-2:0] flash_word_addr,
  input wire [15:0] flash_rdata,
  // cpu
  input wire cpu_sleep,
  output reg cpu_stall,
  output reg cpu_hold,
  output reg nmi_req
);
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_F0 = 3'h3;
  localparam [2:0] ST_F1 = 3'h4;
  localparam [2:0] ST_F2 = 3'h5;

  reg [2:0] state_ff, nxt_state;
  reg [1:0] dly_ff, nxt_dly;
  reg en_ff, nxt_en;
  reg fault_nmi_enable_ff, nxt_fault_nmi_enable;
  reg [1:0] sect_ff, nxt_sect;
  reg busy_ff, nxt_busy;
  reg ok_ff, nxt_ok;
  reg [31:0] crc_ff, nxt_crc;
  reg [31:0] ref_ff, nxt_ref;
  reg [AW-1:0] baddr_ff, nxt_baddr;
  reg [AW-1:0] last_ff, nxt_last;
  reg [7:0] hi_ff, nxt_hi;
  reg w32_ff, nxt_w32;
  reg startup_ff, nxt_startup;
  reg nxt_hold, nxt_stall, nxt_nmi, nxt_frd;
  reg [AW-2:0] nxt_faddr;
  reg [31:0] nxt_rdata;
  reg nxt_wait;
  reg go;
  reg [7:0] cur_byte;
  reg [AW-1:0] ref_start;
  reg match;

  wire wr_go = avs_write && !avs_waitrequest;
  wire [5:0] reg_idx = avs_address[7:2];

  // ------------------------------------------------------------------
  // one byte through the shift register, msb first
  // ------------------------------------------------------------------
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    input w32;
    integer i;
    reg fb;
    reg [31:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        fb = (w32 ? r[31] : r[15]) ^ d[i];
        r = {r[30:0], 1'b0};
        if (fb) begin
          r = r ^ (w32 ? `FCS_POLY32 : `FCS_POLY16);
        end
      end
      if (!w32) begin
        r[31:16] = 16'h0000;
      end
      crc_step = r;
    end
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_dly = dly_ff;
    nxt_en = en_ff;
    nxt_fault_nmi_enable = fault_nmi_enable_ff;
    nxt_sect = sect_ff;
    nxt_busy = busy_ff;
    nxt_ok = ok_ff;
    nxt_crc = crc_ff;
    nxt_ref = ref_ff;
    nxt_baddr = baddr_ff;
    nxt_last = last_ff;
    nxt_hi = hi_ff;
    nxt_w32 = w32_ff;
    nxt_startup = startup_ff;
    nxt_hold = cpu_hold;
    nxt_stall = cpu_stall;
    nxt_nmi = nmi_req;
    nxt_frd = 1'b0;
    nxt_faddr = flash_word_addr;
    go = 1'b0;
    cur_byte = (state_ff == ST_F2) ? hi_ff : flash_rdata[7:0];
    ref_start = last_ff - (w32_ff ? {{(AW-3){1'b0}}, 3'h3} : {{(AW-1){1'b0}}, 1'b1});
    match = 1'b0;
    if (cpu_sleep && state_ff != ST_INIT && state_ff != ST_IDLE) begin
      // flash data lasts one cycle: refetch the word on wake
      if (state_ff == ST_F0 || state_ff == ST_F1) begin
        nxt_state = ST_F0;
        nxt_frd = 1'b1;
      end
    end else begin
      case (state_ff)
        ST_INIT: begin
          if (fuse_scan_source != `FCS_FUSE_NO_SCAN) begin
            nxt_sect = fuse_scan_source;
            nxt_en = 1'b1;
            nxt_busy = 1'b1;
            nxt_startup = 1'b1;
            go = 1'b1;
          end else begin
            nxt_hold = 1'b0;
            nxt_state = ST_IDLE;
          end
        end
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_DELAY: begin
          nxt_dly = dly_ff + 2'h1;
          if (dly_ff == `FCS_START_DELAY - 2'h1) begin
            go = 1'b1;
          end
        end
        ST_F0: begin
          nxt_state = ST_F1;
        end
        ST_F1, ST_F2: begin
          if (state_ff == ST_F1) begin
            nxt_hi = flash_rdata[15:8];
          end
          if (baddr_ff >= ref_start) begin
            if (w32_ff) begin
              nxt_ref = {cur_byte, ref_ff[31:8]};
            end else begin
              nxt_ref = {16'h0000, ref_ff[7:0], cur_byte};
            end
          end else begin
            nxt_crc = crc_step(crc_ff, cur_byte, w32_ff);
          end
          if (baddr_ff == last_ff) begin
            match = (nxt_ref == crc_ff);
            nxt_ok = match;
            nxt_busy = 1'b0;
            nxt_stall = 1'b0;
            nxt_state = ST_IDLE;
            nxt_startup = 1'b0;
            if (!match && fault_nmi_enable_ff) begin
              nxt_nmi = 1'b1;
            end
            if (startup_ff) begin
              nxt_hold = !match;
            end
          end else begin
            nxt_baddr = baddr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (state_ff == ST_F1) begin
              nxt_state = ST_F2;
            end else begin
              nxt_state = ST_F0;
              nxt_frd = 1'b1;
              nxt_faddr = flash_word_addr + {{(AW-2){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    // bus writes
    if (wr_go && !nmi_req) begin
      if (reg_idx == `FCS_IDX_CTRL_FIRST) begin
        if (avs_writedata[`FCS_BIT_FAULT_NMI_ENABLE] && !busy_ff) begin
          nxt_fault_nmi_enable = 1'b1;
        end
        if (avs_writedata[`FCS_BIT_RESET] && (!fault_nmi_enable_ff || !busy_ff)) begin
          nxt_en = 1'b0;
          nxt_sect = `FCS_SEC_FLASH;
          nxt_busy = 1'b0;
          nxt_ok = 1'b0;
          nxt_stall = 1'b0;
          nxt_frd = 1'b0;
          nxt_state = ST_IDLE;
          go = 1'b0;
        end else if (avs_writedata[`FCS_BIT_ENABLE]) begin
          nxt_en = 1'b1;
          nxt_busy = 1'b1;
          nxt_stall = 1'b0;
          nxt_frd = 1'b0;
          nxt_dly = 2'h0;
          nxt_state = ST_DELAY;
          go = 1'b0;
        end
      end
      if (reg_idx == `FCS_IDX_CTRL_SECOND && !busy_ff) begin
        nxt_sect = avs_writedata[1:0];
      end
    end
    // scan start
    if (go) begin
      nxt_state = ST_F0;
      nxt_w32 = fuse_crc32;
      nxt_crc = fuse_crc32 ? `FCS_CRC_INIT32 : `FCS_CRC_INIT16;
      nxt_ref = 32'h00000000;
      nxt_baddr = {AW{1'b0}};
      nxt_faddr = {(AW-1){1'b0}};
      nxt_frd = 1'b1;
      nxt_stall = 1'b1;
      case (nxt_sect)
        `FCS_SEC_BOOT: nxt_last = boot_section_last_byte;
        `FCS_SEC_BOOT_APP: nxt_last = app_section_last_byte;
        default: nxt_last = flash_last_byte;
      endcase
    end
    // bus answer
    nxt_wait = !((avs_read || avs_write) && avs_waitrequest);
    nxt_rdata = 32'h00000000;
    if (avs_read && avs_waitrequest) begin
      if (reg_idx == `FCS_IDX_CTRL_FIRST) begin
        nxt_rdata[`FCS_BIT_ENABLE] = en_ff;
        nxt_rdata[`FCS_BIT_FAULT_NMI_ENABLE] = fault_nmi_enable_ff;
      end else if (reg_idx == `FCS_IDX_CTRL_SECOND) begin
        nxt_rdata[1:0] = sect_ff;
      end else if (reg_idx == `FCS_IDX_STATUS) begin
        nxt_rdata[`FCS_BIT_BUSY] = busy_ff;
        nxt_rdata[`FCS_BIT_OK] = ok_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_INIT;
      dly_ff <= 2'h0;
      en_ff <= 1'b0;
      fault_nmi_enable_ff <= 1'b0;
      sect_ff <= 2'h0;
      busy_ff <= 1'b0;
      ok_ff <= 1'b0;
      crc_ff <= 32'h00000000;
      ref_ff <= 32'h00000000;
      baddr_ff <= {AW{1'b0}};
      last_ff <= {AW{1'b0}};
      hi_ff <= 8'h00;
      w32_ff <= 1'b0;
      startup_ff <= 1'b0;
      cpu_hold <= 1'b1;
      cpu_stall <= 1'b0;
      nmi_req <= 1'b0;
      flash_rd <= 1'b0;
      flash_word_addr <= {(AW-1){1'b0}};
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      dly_ff <= nxt_dly;
      en_ff <= nxt_en;
      fault_nmi_enable_ff <= nxt_fault_nmi_enable;
      sect_ff <= nxt_sect;
      busy_ff <= nxt_busy;
      ok_ff <= nxt_ok;
      crc_ff <= nxt_crc;
      ref_ff <= nxt_ref;
      baddr_ff <= nxt_baddr;
      last_ff <= nxt_last;
      hi_ff <= nxt_hi;
      w32_ff <= nxt_w32;
      startup_ff <= nxt_startup;
      cpu_hold <= nxt_hold;
      cpu_stall <= nxt_stall;
      nmi_req <= nxt_nmi;
      flash_rd <= nxt_frd;
      flash_word_addr <= nxt_faddr;
      avs_readdata <= nxt_rdata;
      avs_waitrequest <= nxt_wait;
    end
  end
endmodule

/* File: test/fcs_scanner_chk_sva.sv */
`timescale 1ns/1ns
// ---
// checker on scanner ports
// ---
module fcs_scanner_chk #(
  parameter AW = 16
) (
  // clock, reset, bus
  input wire mclk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  // flash and cpu
  input wire flash_rd,
  input wire [AW-2:0] flash_word_addr,
  input wire cpu_sleep,
  input wire cpu_stall,
  input wire nmi_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_en_wr;
    avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00 && avs_writedata[0]
      && !avs_writedata[7] && !nmi_req && !cpu_stall;
  endsequence
  sequence s_word;
    (flash_rd && !cpu_sleep) ##1 !cpu_sleep;
  endsequence
  a_start_delay: assert property (s_en_wr ##1 !cpu_sleep [*3] |=> cpu_stall)
    else $error("scan start late");
  a_delay_quiet: assert property (s_en_wr |=> !cpu_stall [*3])
    else $error("cpu stalled during start delay");
  a_first_zero: assert property ($rose(cpu_stall) |-> flash_rd && flash_word_addr == 0)
    else $error("scan not from address zero");
  a_fetch_gap: assert property (s_word |-> !flash_rd ##1 !flash_rd)
    else $error("fetch shorter than three cycles");
  a_addr_step: assert property (s_word ##1 !cpu_sleep ##1 flash_rd |->
    flash_word_addr == $past(flash_word_addr, 3) + 1'b1)
    else $error("word address skipped");
  a_stall_rd: assert property (flash_rd |-> cpu_stall)
    else $error("flash read without stall");
  a_wait_one: assert property ($rose(avs_read || avs_write) |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus wait not one cycle");
  a_nmi_sticky: assert property (nmi_req |=> nmi_req)
    else $error("nmi request dropped");
  a_nmi_end: assert property ($rose(nmi_req) |-> $fell(cpu_stall))
    else $error("nmi not at scan end");
  a_sleep_hold: assert property (cpu_sleep && !cpu_stall |=> !flash_rd)
    else $error("scan ran in sleep");
endmodule
bind fcs_scanner fcs_scanner_chk #(.AW(AW)) u_chk (.mclk(mclk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .flash_rd(flash_rd),
  .flash_word_addr(flash_word_addr), .cpu_sleep(cpu_sleep), .cpu_stall(cpu_stall),
  .nmi_req(nmi_req));

/* File: test/fcs_flash_model.sv */
`timescale 1ns/1ns
// ---
// flash: one cycle latency, changing pattern when idle
// ---
module fcs_flash_model (
  input wire mclk,
  input wire flash_rd,
  input wire [14:0] flash_word_addr,
  output reg [15:0] flash_rdata
);
  reg [7:0] mem [0:63];
  initial flash_rdata = 16'h0000;
  always @(posedge mclk) begin
    if (flash_rd) begin
      flash_rdata <= {mem[{flash_word_addr[4:0], 1'b1}], mem[{flash_word_addr[4:0], 1'b0}]};
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule

/* File: test/test_flash_crc_memory_scanner.sv */
`timescale 1ns/1ns
module test_flash_crc_memory_scanner;
  reg mclk, rst, avs_read, avs_write, fuse_crc32, cpu_sleep;
  reg [7:0] avs_address;
  reg [31:0] avs_writedata, rd;
  reg [1:0] fuse_scan_source;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, flash_rd, cpu_stall, cpu_hold, nmi_req;
  wire [14:0] flash_word_addr;
  wire [15:0] flash_rdata;
  integer n_mismatch, samples_checked, k;
  fcs_scanner u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fuse_crc32(fuse_crc32),
    .fuse_scan_source(fuse_scan_source), .boot_section_last_byte(16'h000F),
    .app_section_last_byte(16'h001F), .flash_last_byte(16'h003F), .flash_rd(flash_rd),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata), .cpu_sleep(cpu_sleep),
    .cpu_stall(cpu_stall), .cpu_hold(cpu_hold), .nmi_req(nmi_req));
  fcs_flash_model u_flash (.mclk(mclk), .flash_rd(flash_rd),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // ---
  // tasks
  // ---
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    integer i;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      i = 0;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) begin
        i = i + 1;
        if (i > 20) begin
          n_mismatch = n_mismatch + 1;
          wrap_up;
        end
        @(posedge mclk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wait_idle;
    integer j;
    begin
      j = 0;
      rd = 1;
      while (rd[0] !== 1'b0) begin
        j = j + 1;
        if (j > 400) begin
          n_mismatch = n_mismatch + 1;
          wrap_up;
        end
        bus(0, 8'h08, 0);
      end
    end
  endtask
  function automatic [31:0] crc(input w, input integer n);
    integer i, b;
    reg [31:0] c;
    begin
      c = w ? 32'hFFFFFFFF : 32'h0000FFFF;
      for (i = 0; i < n; i = i + 1)
        for (b = 7; b >= 0; b = b - 1)
          c = ((c << 1) ^ (((w ? c[31] : c[15]) ^ u_flash.mem[i][b]) ?
            (w ? 32'h04C11DB7 : 32'h00001021) : 32'h0)) & (w ? 32'hFFFFFFFF : 32'h0000FFFF);
      crc = c;
    end
  endfunction
  function integer last_of(input [1:0] s);
    last_of = s == 2'h2 ? 15 : s == 2'h1 ? 31 : 63;
  endfunction
  task put_ref(input w, input integer last, input good);
    reg [31:0] r;
    begin
      r = crc(w, last + 1 - (w ? 4 : 2));
      if (w) {u_flash.mem[last], u_flash.mem[last-1], u_flash.mem[last-2],
        u_flash.mem[last-3]} = r;
      else {u_flash.mem[last-1], u_flash.mem[last]} = r[15:0];
      u_flash.mem[last] = u_flash.mem[last] ^ {7'h00, !good};
    end
  endtask
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    fuse_crc32 = 0;
    cpu_sleep = 0;
    fuse_scan_source = 2'h2;
    for (k = 0; k < 64; k = k + 1) u_flash.mem[k] = k[7:0] * 8'h1D + 8'h05;
    put_ref(0, 15, 1);
    repeat (4) @(posedge mclk);
    rst <= 0;
    k = 0;
    while (cpu_hold !== 1'b0 && k < 300) begin
      @(posedge mclk);
      k = k + 1;
    end
    chk(cpu_hold, 0);
    bus(0, 8'h00, 0);
    chk(rd[1:0], 2'h1);
    bus(0, 8'h04, 0);
    chk(rd[1:0], 2'h2);
    wait_idle;
    chk(rd[1:0], 2'h2);
    bus(0, 8'h0C, 0);
    chk(rd, 0);
    for (k = 0; k < 8; k = k + 1) begin
      fuse_crc32 <= k[2];
      put_ref(k[2], last_of(k[1:0]), 1);
      bus(1, 8'h04, k[1:0]);
      bus(1, 8'h00, 32'h1);
      wait_idle;
      chk(rd[1:0], 2'h2);
    end
    fuse_crc32 <= 0;
    put_ref(0, 15, 1);
    bus(1, 8'h04, 32'h2);
    bus(1, 8'h00, 32'h1);
    repeat (3) @(posedge mclk);
    cpu_sleep <= 1;
    repeat (6) @(posedge mclk);
    chk(cpu_stall, 1);
    cpu_sleep <= 0;
    wait_idle;
    chk(rd[1:0], 2'h2);
    put_ref(0, 15, 0);
    bus(1, 8'h04, 32'h2);
    bus(1, 8'h00, 32'h1);
    cpu_sleep <= 1;
    repeat (10) @(posedge mclk);
    chk(cpu_stall, 0);
    cpu_sleep <= 0;
    wait_idle;
    chk(rd[1:0], 2'h0);
    chk(nmi_req, 0);
    bus(1, 8'h00, 32'h0);
    bus(0, 8'h00, 0);
    chk(rd[0], 1);
    bus(1, 8'h00, 32'h2);
    bus(1, 8'h00, 32'h1);
    wait_idle;
    chk(nmi_req, 1);
    bus(1, 8'h00, 32'h80);
    bus(0, 8'h00, 0);
    chk(rd[1:0], 2'h3);
    rst <= 1;
    repeat (4) @(posedge mclk);
    rst <= 0;
    repeat (2) @(posedge mclk);
    wait_idle;
    chk(rd[1:0], 2'h0);
    chk(cpu_hold, 1);
    chk(nmi_req, 0);
    bus(0, 8'h04, 0);
    chk(rd[1:0], 2'h2);
    bus(0, 8'h00, 0);
    chk(rd[1:0], 2'h1);
    fuse_scan_source <= 2'h3;
    rst <= 1;
    repeat (4) @(posedge mclk);
    rst <= 0;
    repeat (2) @(posedge mclk);
    chk(cpu_hold, 0);
    chk(cpu_stall, 0);
    bus(0, 8'h00, 0);
    chk(rd[1:0], 2'h0);
    bus(1, 8'h04, 32'h1);
    bus(1, 8'h00, 32'h2);
    bus(1, 8'h00, 32'h80);
    bus(0, 8'h00, 0);
    chk(rd[1:0], 2'h2);
    bus(0, 8'h04, 0);
    chk(rd[1:0], 2'h0);
    wrap_up;
  end
endmodule
